// >>> hdl/can_gw_pkg.sv
// package for the two-node gateway engine: object layout, register map, codes.
// assumes 32-bit classic wishbone and up to 32 message objects.
package can_gw_pkg;
  localparam int OBJ_W = 5;
  localparam int ID_W = 29;
  localparam int DLC_W = 4;
  localparam int DATA_W = 64;

  typedef logic [1:0] flag_t;
  localparam flag_t FLAG_RESET = 2'h1;
  localparam flag_t FLAG_SET = 2'h2;

  localparam logic [2:0] MODE_STD = 3'h0;
  localparam logic [1:0] MODE_FIFO_HI = 2'h1;
  localparam logic [2:0] MODE_GW = 3'h4;

  typedef struct packed {
    logic node;
    logic dir;
    logic [2:0] mode;
    logic [OBJ_W-1:0] ptr;
    logic [OBJ_W-1:0] buffer_length_field;
    logic identifier_copy_bit;
    logic length_code_copy_bit;
    logic gateway_auto_tx_bit;
    logic remote_forward_enable;
    flag_t transmit_request_flag;
    flag_t rmt;
    flag_t cpu_update_flag;
    logic [ID_W-1:0] id;
    logic [DLC_W-1:0] dlc;
    logic [DATA_W-1:0] data;
  } obj_t;

  localparam obj_t OBJ_RESET = '{node: 1'b0, dir: 1'b0, mode: MODE_STD, ptr: '0, buffer_length_field: '0,
    identifier_copy_bit: 1'b0, length_code_copy_bit: 1'b0, gateway_auto_tx_bit: 1'b0, remote_forward_enable: 1'b0, transmit_request_flag: FLAG_RESET, rmt: FLAG_RESET,
    cpu_update_flag: FLAG_RESET, id: '0, dlc: '0, data: '0};

  // byte address = object * 32 + register index * 4
  localparam int ADR_REG_LSB = 2;
  localparam int ADR_REG_W = 3;
  localparam int ADR_OBJ_LSB = 5;
  localparam int ADR_W = 10;
  localparam logic [2:0] REG_CFG = 3'h0;
  localparam logic [2:0] REG_FGCR = 3'h1;
  localparam logic [2:0] REG_CTRL = 3'h2;
  localparam logic [2:0] REG_ID = 3'h3;
  localparam logic [2:0] REG_DLC = 3'h4;
  localparam logic [2:0] REG_DATA_LO = 3'h5;
  localparam logic [2:0] REG_DATA_HI = 3'h6;

  // field positions
  localparam int CFG_NODE = 0;
  localparam int CFG_DIR = 1;
  localparam int FG_MODE = 0;
  localparam int FG_PTR = 8;
  localparam int FG_BUFFER_LENGTH_FIELD = 16;
  localparam int FG_IDC = 24;
  localparam int FG_LENGTH_CODE_COPY_BIT = 25;
  localparam int FG_GATEWAY_AUTO_TX_BIT = 26;
  localparam int FG_REMOTE_FORWARD_ENABLE = 27;
  localparam int CT_TRANSMIT_REQUEST_FLAG = 0;
  localparam int CT_RMT = 2;
  localparam int CT_CPU_UPDATE_FLAG = 4;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_STORE = 2'b01,
    ST_COPY = 2'b10
  } state_t;
endpackage

// >>> hdl/can_gw_fifo_ptr.sv
// fifo element pointer advance inside a power-of-two buffer.
// assumes the mask equals buffer length minus one and base is length aligned.
`timescale 1ns/10ps
module can_gw_fifo_ptr #(
  parameter int W = 5
) (
  input wire logic [W-1:0] ptrOld, // current element number
  input wire logic [W-1:0] sizeMask, // buffer length field
  output logic [W-1:0] ptrNew // next element number
);
  logic [W-1:0] ptrInc;

  always_comb begin
    ptrInc = ptrOld + W'(1);
    ptrNew = (ptrOld & ~sizeMask) | (ptrInc & sizeMask);
  end
endmodule

// >>> hdl/can_normal_gateway_transfer.sv
// normal gateway engine: shared message objects, two node controllers, wishbone registers.
// assumes node controllers deliver matched frames as pulses and report finished sends.
// Contract
// - each object serves only the node named by its node bit.
// - data frames go source to destination; remote frames destination to source.
// - all eight data bytes are copied into the destination object.
// - identifier copied when identifier copy bit set, else left unchanged.
// - length code copied when the length code copy bit is set.
// - auto transmit bit sets destination transmit request; sends only when update reset.
// - standard destination never forwards remote frames; answers them directly instead.
// - copy into standard destination loads its pointer with its own number.
// - direct answer sets transmit request and remote pending; sends when update reset.
// - gateway destination forwards remote frames when enabled, else answers locally.
// - cpu transmit request on source gateway object sends a remote frame.
// - fifo destination: source pointer picks element and advances after each copy.
// - auto transmit bit decides transmit request of the chosen fifo element.
// - pointer advance keeps bits outside the mask, increments bits inside.
//
// Chosen here: the address map and the Wishbone register port.
`timescale 1ns/10ps
module can_normal_gateway_transfer #(
  parameter int NUM_OBJ = 32
) (
  input wire logic sys_clk, // 100 MHz clock
  input wire logic rst, // async reset, active high
  input wire logic ce, // clock enable, freezes state when low
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write
  input wire logic [can_gw_pkg::ADR_W-1:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  input wire logic rxValid, // matched frame received
  input wire logic rxNode, // receiving node
  input wire logic [can_gw_pkg::OBJ_W-1:0] rxObj, // matched object
  input wire logic rxRemote, // frame is a remote frame
  input wire logic [can_gw_pkg::ID_W-1:0] rxId, // frame identifier
  input wire logic [can_gw_pkg::DLC_W-1:0] rxDlc, // frame length code
  input wire logic [can_gw_pkg::DATA_W-1:0] rxData, // frame data
  output logic rxReady, // engine can take a frame
  input wire logic [1:0] nodeBusy, // node cannot start a send
  input wire logic txDone, // send finished
  input wire logic [can_gw_pkg::OBJ_W-1:0] txDoneObj, // object that was sent
  output logic txStart, // send launch pulse
  output logic txNode, // node to send on
  output logic [can_gw_pkg::OBJ_W-1:0] txObj, // object sent
  output logic txRemote, // send a remote frame
  output logic [can_gw_pkg::ID_W-1:0] txId, // identifier to send
  output logic [can_gw_pkg::DLC_W-1:0] txDlc, // length code to send
  output logic [can_gw_pkg::DATA_W-1:0] txData // data to send
);
  localparam int OW = can_gw_pkg::OBJ_W;

  can_gw_pkg::obj_t obj_q [NUM_OBJ];
  can_gw_pkg::obj_t obj_d [NUM_OBJ];
  can_gw_pkg::state_t state_q, state_d;
  logic evNode_q, evNode_d, evRemote_q, evRemote_d;
  logic [OW-1:0] evObj_q, evObj_d, dst_q, dst_d;
  logic [can_gw_pkg::ID_W-1:0] evId_q, evId_d;
  logic [can_gw_pkg::DLC_W-1:0] evDlc_q, evDlc_d;
  logic [can_gw_pkg::DATA_W-1:0] evData_q, evData_d;
  logic [1:0] inflight_q, inflight_d;
  logic rxReady_q, rxReady_d, ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic txStart_q, txStart_d, txNode_q, txNode_d, txRemote_q, txRemote_d;
  logic [OW-1:0] txObj_q, txObj_d;
  logic [can_gw_pkg::ID_W-1:0] txId_q, txId_d;
  logic [can_gw_pkg::DLC_W-1:0] txDlc_q, txDlc_d;
  logic [can_gw_pkg::DATA_W-1:0] txData_q, txData_d;

  logic [OW-1:0] busObj, srcPtrNext;
  logic [2:0] busReg;
  logic busHit, busReq;
  logic [31:0] busOld, busNew, selMask;
  can_gw_pkg::obj_t bo, so, dsto;

  assign busObj = wb_adr_i[can_gw_pkg::ADR_OBJ_LSB +: OW];
  assign busReg = wb_adr_i[can_gw_pkg::ADR_REG_LSB +: can_gw_pkg::ADR_REG_W];
  assign busHit = (32'(busObj) < NUM_OBJ) && (busReg <= can_gw_pkg::REG_DATA_HI);
  assign busReq = wb_cyc_i && wb_stb_i && !ack_q;

  can_gw_fifo_ptr #(.W(OW)) fifoPtr (
    .ptrOld(obj_q[evObj_q].ptr),
    .sizeMask(obj_q[evObj_q].buffer_length_field),
    .ptrNew(srcPtrNext)
  );

  // register view of the addressed object
  always_comb begin
    bo = busHit ? obj_q[busObj] : can_gw_pkg::OBJ_RESET;
    busOld = 32'h0000_0000;
    unique case (busReg)
      can_gw_pkg::REG_CFG: begin
        busOld[can_gw_pkg::CFG_NODE] = bo.node;
        busOld[can_gw_pkg::CFG_DIR] = bo.dir;
      end
      can_gw_pkg::REG_FGCR: begin
        busOld[can_gw_pkg::FG_MODE +: 3] = bo.mode;
        busOld[can_gw_pkg::FG_PTR +: OW] = bo.ptr;
        busOld[can_gw_pkg::FG_BUFFER_LENGTH_FIELD +: OW] = bo.buffer_length_field;
        busOld[can_gw_pkg::FG_IDC] = bo.identifier_copy_bit;
        busOld[can_gw_pkg::FG_LENGTH_CODE_COPY_BIT] = bo.length_code_copy_bit;
        busOld[can_gw_pkg::FG_GATEWAY_AUTO_TX_BIT] = bo.gateway_auto_tx_bit;
        busOld[can_gw_pkg::FG_REMOTE_FORWARD_ENABLE] = bo.remote_forward_enable;
      end
      can_gw_pkg::REG_CTRL: begin
        busOld[can_gw_pkg::CT_TRANSMIT_REQUEST_FLAG +: 2] = bo.transmit_request_flag;
        busOld[can_gw_pkg::CT_RMT +: 2] = bo.rmt;
        busOld[can_gw_pkg::CT_CPU_UPDATE_FLAG +: 2] = bo.cpu_update_flag;
      end
      can_gw_pkg::REG_ID: busOld[can_gw_pkg::ID_W-1:0] = bo.id;
      can_gw_pkg::REG_DLC: busOld[can_gw_pkg::DLC_W-1:0] = bo.dlc;
      can_gw_pkg::REG_DATA_LO: busOld = bo.data[31:0];
      can_gw_pkg::REG_DATA_HI: busOld = bo.data[63:32];
      default: busOld = 32'h0000_0000;
    endcase
    if (!busHit) begin
      busOld = 32'h0000_0000;
    end
    selMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    busNew = (busOld & ~selMask) | (wb_dat_i & selMask);
  end

  always_comb begin
    obj_d = obj_q;
    state_d = state_q;
    evNode_d = evNode_q;
    evRemote_d = evRemote_q;
    evObj_d = evObj_q;
    evId_d = evId_q;
    evDlc_d = evDlc_q;
    evData_d = evData_q;
    dst_d = dst_q;
    inflight_d = inflight_q;
    ack_d = 1'b0;
    rdat_d = rdat_q;
    txStart_d = 1'b0;
    txNode_d = txNode_q;
    txObj_d = txObj_q;
    txRemote_d = txRemote_q;
    txId_d = txId_q;
    txDlc_d = txDlc_q;
    txData_d = txData_q;
    so = obj_q[evObj_q];
    dsto = obj_q[dst_q];

    // finished send clears the request first so a set in this cycle wins
    if (txDone && (32'(txDoneObj) < NUM_OBJ)) begin
      obj_d[txDoneObj].transmit_request_flag = can_gw_pkg::FLAG_RESET;
      obj_d[txDoneObj].rmt = can_gw_pkg::FLAG_RESET;
      inflight_d[obj_q[txDoneObj].node] = 1'b0;
    end

    unique case (state_q)
      can_gw_pkg::ST_IDLE: begin
        if (rxValid) begin
          evNode_d = rxNode;
          evRemote_d = rxRemote;
          evObj_d = rxObj;
          evId_d = rxId;
          evDlc_d = rxDlc;
          evData_d = rxData;
          state_d = can_gw_pkg::ST_STORE;
        end else if (busReq) begin
          ack_d = 1'b1;
          rdat_d = busOld;
          if (wb_we_i && busHit) begin
            unique case (busReg)
              can_gw_pkg::REG_CFG: begin
                obj_d[busObj].node = busNew[can_gw_pkg::CFG_NODE];
                obj_d[busObj].dir = busNew[can_gw_pkg::CFG_DIR];
              end
              can_gw_pkg::REG_FGCR: begin
                obj_d[busObj].mode = busNew[can_gw_pkg::FG_MODE +: 3];
                obj_d[busObj].ptr = busNew[can_gw_pkg::FG_PTR +: OW];
                obj_d[busObj].buffer_length_field = busNew[can_gw_pkg::FG_BUFFER_LENGTH_FIELD +: OW];
                obj_d[busObj].identifier_copy_bit = busNew[can_gw_pkg::FG_IDC];
                obj_d[busObj].length_code_copy_bit = busNew[can_gw_pkg::FG_LENGTH_CODE_COPY_BIT];
                obj_d[busObj].gateway_auto_tx_bit = busNew[can_gw_pkg::FG_GATEWAY_AUTO_TX_BIT];
                obj_d[busObj].remote_forward_enable = busNew[can_gw_pkg::FG_REMOTE_FORWARD_ENABLE];
              end
              can_gw_pkg::REG_CTRL: begin
                obj_d[busObj].transmit_request_flag = busNew[can_gw_pkg::CT_TRANSMIT_REQUEST_FLAG +: 2];
                obj_d[busObj].rmt = busNew[can_gw_pkg::CT_RMT +: 2];
                obj_d[busObj].cpu_update_flag = busNew[can_gw_pkg::CT_CPU_UPDATE_FLAG +: 2];
              end
              can_gw_pkg::REG_ID: obj_d[busObj].id = busNew[can_gw_pkg::ID_W-1:0];
              can_gw_pkg::REG_DLC: obj_d[busObj].dlc = busNew[can_gw_pkg::DLC_W-1:0];
              can_gw_pkg::REG_DATA_LO: obj_d[busObj].data[31:0] = busNew;
              can_gw_pkg::REG_DATA_HI: obj_d[busObj].data[63:32] = busNew;
              default: obj_d[busObj].data = obj_q[busObj].data;
            endcase
          end
        end
        // send launch only from idle, so a copy is never half done
        for (int n = 0; n < 2; n++) begin
          for (int i = NUM_OBJ - 1; i >= 0; i--) begin
            if (!txStart_d && !inflight_q[n] && !nodeBusy[n] && obj_q[i].node == 1'(n)
                && obj_q[i].transmit_request_flag == can_gw_pkg::FLAG_SET
                && (!obj_q[i].dir || obj_q[i].cpu_update_flag == can_gw_pkg::FLAG_RESET)) begin
              txStart_d = 1'b1;
              txNode_d = 1'(n);
              txObj_d = OW'(i);
              txRemote_d = !obj_q[i].dir;
              txId_d = obj_q[i].id;
              txDlc_d = obj_q[i].dlc;
              txData_d = obj_q[i].data;
            end
          end
          if (txStart_d && txNode_d == 1'(n)) begin
            inflight_d[n] = 1'b1;
          end
        end
      end
      can_gw_pkg::ST_STORE: begin
        state_d = can_gw_pkg::ST_IDLE;
        if (32'(evObj_q) < NUM_OBJ && so.node == evNode_q) begin
          if (evRemote_q && so.dir) begin
            if (so.mode == can_gw_pkg::MODE_GW && so.remote_forward_enable && 32'(so.ptr) < NUM_OBJ) begin
              obj_d[so.ptr].transmit_request_flag = can_gw_pkg::FLAG_SET;
            end else begin
              obj_d[evObj_q].transmit_request_flag = can_gw_pkg::FLAG_SET;
              obj_d[evObj_q].rmt = can_gw_pkg::FLAG_SET;
            end
          end else if (!evRemote_q && !so.dir) begin
            obj_d[evObj_q].id = evId_q;
            obj_d[evObj_q].dlc = evDlc_q;
            obj_d[evObj_q].data = evData_q;
            if (so.mode == can_gw_pkg::MODE_GW && 32'(so.ptr) < NUM_OBJ) begin
              dst_d = so.ptr;
              state_d = can_gw_pkg::ST_COPY;
            end
          end
        end
      end
      can_gw_pkg::ST_COPY: begin
        state_d = can_gw_pkg::ST_IDLE;
        obj_d[dst_q].data = so.data;
        if (so.identifier_copy_bit) begin
          obj_d[dst_q].id = so.id;
        end
        if (so.length_code_copy_bit) begin
          obj_d[dst_q].dlc = so.dlc;
        end
        if (dsto.mode == can_gw_pkg::MODE_STD) begin
          obj_d[dst_q].ptr = dst_q;
        end
        if (so.gateway_auto_tx_bit) begin
          obj_d[dst_q].transmit_request_flag = can_gw_pkg::FLAG_SET;
        end
        if (dsto.mode[2:1] == can_gw_pkg::MODE_FIFO_HI) begin
          obj_d[evObj_q].ptr = srcPtrNext;
        end
      end
      default: state_d = can_gw_pkg::ST_IDLE;
    endcase
    rxReady_d = (state_d == can_gw_pkg::ST_IDLE);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_OBJ; i++) begin
        obj_q[i] <= can_gw_pkg::OBJ_RESET;
      end
      state_q <= can_gw_pkg::ST_IDLE;
      evNode_q <= 1'b0;
      evRemote_q <= 1'b0;
      evObj_q <= '0;
      evId_q <= '0;
      evDlc_q <= '0;
      evData_q <= '0;
      dst_q <= '0;
      inflight_q <= 2'h0;
      rxReady_q <= 1'b1;
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
      txStart_q <= 1'b0;
      txNode_q <= 1'b0;
      txObj_q <= '0;
      txRemote_q <= 1'b0;
      txId_q <= '0;
      txDlc_q <= '0;
      txData_q <= '0;
    end else if (ce) begin
      obj_q <= obj_d;
      state_q <= state_d;
      evNode_q <= evNode_d;
      evRemote_q <= evRemote_d;
      evObj_q <= evObj_d;
      evId_q <= evId_d;
      evDlc_q <= evDlc_d;
      evData_q <= evData_d;
      dst_q <= dst_d;
      inflight_q <= inflight_d;
      rxReady_q <= rxReady_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      txStart_q <= txStart_d;
      txNode_q <= txNode_d;
      txObj_q <= txObj_d;
      txRemote_q <= txRemote_d;
      txId_q <= txId_d;
      txDlc_q <= txDlc_d;
      txData_q <= txData_d;
    end
  end

  assign wb_dat_o = rdat_q;
  assign wb_ack_o = ack_q;
  assign rxReady = rxReady_q;
  assign txStart = txStart_q;
  assign txNode = txNode_q;
  assign txObj = txObj_q;
  assign txRemote = txRemote_q;
  assign txId = txId_q;
  assign txDlc = txDlc_q;
  assign txData = txData_q;
endmodule

// >>> sim/can_gw_assertions.sv
// checker for the gateway engine ports: bus answer, frame intake and send launch timing.
// assumes clock enable held high whenever properties are meant to hold.
`timescale 1ns/10ps
module can_gw_assertions (
  input wire logic sys_clk, // clock
  input wire logic rst, // async reset, active high
  input wire logic ce, // clock enable
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // bus strobe
  input wire logic wb_ack_o, // bus acknowledge
  input wire logic rxValid, // frame offered
  input wire logic rxReady, // engine idle
  input wire logic [1:0] nodeBusy, // node cannot send
  input wire logic txStart, // launch pulse
  input wire logic txNode, // launch node
  input wire logic [can_gw_pkg::OBJ_W-1:0] txObj, // launched object
  input wire logic [can_gw_pkg::DATA_W-1:0] txData // launched data
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst || !ce);

  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_has_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  a_frame_taken: assert property (rxValid && rxReady |=> !rxReady)
    else $error("frame not taken");
  a_copy_bounded: assert property ($fell(rxReady) |-> ##[1:2] rxReady)
    else $error("frame handling too long");
  a_start_pulse: assert property (txStart |=> !txStart)
    else $error("launch pulse too long");
  a_launch_idle: assert property (txStart |-> $past(rxReady))
    else $error("launch during frame copy");
  a_fields_stand: assert property (!txStart |-> $stable(txData) && $stable(txObj))
    else $error("send fields changed without launch");
  a_node_free: assert property (txStart |-> !(txNode ? $past(nodeBusy[1]) : $past(nodeBusy[0])))
    else $error("launch on a busy node");
endmodule

bind can_normal_gateway_transfer can_gw_assertions i_can_gw_assertions (
  .sys_clk(sys_clk), .rst(rst), .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .rxValid(rxValid), .rxReady(rxReady), .nodeBusy(nodeBusy),
  .txStart(txStart), .txNode(txNode), .txObj(txObj), .txData(txData));

// >>> sim/can_node_model.sv
// model of the two node controllers: takes launches, reports finished sends.
// assumes one send in flight per node; finish reports are serialised, node 0 first.
`timescale 1ns/10ps
module can_node_model (
  input wire logic sys_clk, // clock
  input wire logic rst, // async reset, active high
  input wire logic slow, // long frames when high
  input wire logic txStart, // launch pulse
  input wire logic txNode, // node to send on
  input wire logic [4:0] txObj, // object sent
  output logic [1:0] nodeBusy, // send in flight per node
  output logic txDone, // send finished pulse
  output logic [4:0] txDoneObj // object finished
);
  logic [4:0] cnt [2];
  logic [4:0] obj [2];
  logic fired;
  assign nodeBusy = {cnt[1] != 5'h0, cnt[0] != 5'h0};
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt <= '{5'h0, 5'h0};
      obj <= '{5'h0, 5'h0};
      txDone <= 1'b0;
      txDoneObj <= 5'h0;
    end else begin
      fired = 1'b0;
      txDone <= 1'b0;
      // object number is meaningless outside the finish pulse
      txDoneObj <= ~txDoneObj;
      for (int n = 0; n < 2; n++) begin
        if (txStart && txNode == n[0]) begin
          cnt[n] <= slow ? 5'h14 : 5'h3;
          obj[n] <= txObj;
        end else if (cnt[n] == 5'h1 && !fired) begin
          fired = 1'b1;
          cnt[n] <= 5'h0;
          txDone <= 1'b1;
          txDoneObj <= obj[n];
        end else if (cnt[n] > 5'h1) begin
          cnt[n] <= cnt[n] - 5'h1;
        end
      end
    end
  end
endmodule

// >>> sim/can_normal_gateway_transfer_test.sv
// testbench: gateway engine with a wishbone master, frame driver and node model.
// assumes the register map and timing of the designer's hand-over.
`timescale 1ns/10ps
module can_normal_gateway_transfer_test;
  localparam logic [63:0] D1 = 64'h0123_4567_89ab_cdef;
  localparam logic [63:0] D2 = 64'hfedc_ba98_7654_3210;
  localparam logic [63:0] D3 = 64'h5a5a_0f0f_c3c3_9696;
  localparam logic [28:0] ID1 = 29'h0abc_1234;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic slow = 1'b0;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [9:0] wbAdr = '0;
  logic [31:0] wbDat = '0;
  logic [31:0] rdDat;
  logic [31:0] q;
  logic ack, rxReady, txDone, txStart, txNode, txRemote;
  logic rxValid = 1'b0;
  logic rxNode = 1'b0;
  logic rxRemote = 1'b0;
  logic [4:0] rxObj = '0;
  logic [4:0] txDoneObj, txObj;
  logic [28:0] rxId = '0;
  logic [28:0] txId;
  logic [3:0] rxDlc = '0;
  logic [3:0] txDlc;
  logic [63:0] rxData = '0;
  logic [63:0] txData;
  logic [1:0] nodeBusy;
  int numErrors = 0;
  int testsRun = 0;
  int cycles = 0;

  always #5 sys_clk = ~sys_clk;

  can_normal_gateway_transfer #(.NUM_OBJ(32)) i_can_normal_gateway_transfer (
    .sys_clk(sys_clk), .rst(rst), .ce(1'b1), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(4'hf), .wb_dat_i(wbDat), .wb_dat_o(rdDat), .wb_ack_o(ack),
    .rxValid(rxValid), .rxNode(rxNode), .rxObj(rxObj), .rxRemote(rxRemote), .rxId(rxId),
    .rxDlc(rxDlc), .rxData(rxData), .rxReady(rxReady), .nodeBusy(nodeBusy), .txDone(txDone),
    .txDoneObj(txDoneObj), .txStart(txStart), .txNode(txNode), .txObj(txObj),
    .txRemote(txRemote), .txId(txId), .txDlc(txDlc), .txData(txData));

  can_node_model i_can_node_model (
    .sys_clk(sys_clk), .rst(rst), .slow(slow), .txStart(txStart), .txNode(txNode),
    .txObj(txObj), .nodeBusy(nodeBusy), .txDone(txDone), .txDoneObj(txDoneObj));

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    testsRun++;
    if (seen !== exp) begin
      numErrors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", testsRun, numErrors);
    if (numErrors == 0 && testsRun > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      numErrors++;
      report_and_stop();
    end
  end

  // flags: forward, auto tx, length copy, id copy
  function automatic logic [31:0] fg(input logic [2:0] m, input logic [4:0] p, input logic [4:0] s,
      input logic [3:0] f);
    return {4'h0, f, 3'h0, s, 3'h0, p, 5'h0, m};
  endfunction

  task automatic wb(input logic we, input logic [4:0] o, input logic [2:0] r, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge sys_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= {o, r, 2'h0};
    wbDat <= d;
    // ack and read data are taken at the rising edge that samples ack high
    do begin
      @(posedge sys_clk);
      t++;
    end while (ack !== 1'b1 && t < 100);
    if (t >= 100)
      numErrors++;
    q = rdDat;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] o, input logic [2:0] r, input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, o, r, 32'h0000_0000);
    chk(q & m, e);
  endtask

  task automatic cfg(input logic [4:0] o, input logic n, input logic d, input logic [31:0] f);
    wb(1'b1, o, can_gw_pkg::REG_CFG, {30'h0, d, n});
    wb(1'b1, o, can_gw_pkg::REG_FGCR, f);
  endtask

  task automatic rx(input logic n, input logic [4:0] o, input logic r, input logic [28:0] id,
      input logic [3:0] dl, input logic [63:0] d);
    int t;
    t = 0;
    do begin
      @(negedge sys_clk);
      t++;
    end while (rxReady !== 1'b1 && t < 50);
    @(posedge sys_clk);
    rxValid <= 1'b1;
    rxNode <= n;
    rxObj <= o;
    rxRemote <= r;
    rxId <= id;
    rxDlc <= dl;
    rxData <= d;
    @(posedge sys_clk);
    rxValid <= 1'b0;
    rxData <= ~d;
  endtask

  task automatic exp_tx(input logic n, input logic [4:0] o, input logic r, input logic [63:0] d);
    int t;
    t = 0;
    do begin
      @(negedge sys_clk);
      t++;
    end while (txStart !== 1'b1 && t < 60);
    chk(t < 60, 1'b1);
    chk({txNode, txObj, txRemote}, {n, o, r});
    if (!r)
      chk(txData, d);
  endtask

  task automatic no_tx();
    repeat (12) begin
      @(negedge sys_clk);
      chk(txStart, 1'b0);
    end
  endtask

  task automatic t_reset();
    rd(5'h03, can_gw_pkg::REG_CTRL, 32'hffff_ffff, 32'h0000_0015);
    rd(5'h03, can_gw_pkg::REG_CFG, 32'hffff_ffff, 32'h0000_0000);
    wb(1'b1, 5'h03, 3'h7, 32'hffff_ffff);
    rd(5'h03, 3'h7, 32'hffff_ffff, 32'h0000_0000);
    $display("reset and unmapped test done");
  endtask

  task automatic t_std();
    cfg(5'h01, 1'b0, 1'b0, fg(can_gw_pkg::MODE_GW, 5'h05, 5'h00, 4'h7));
    cfg(5'h05, 1'b1, 1'b1, fg(can_gw_pkg::MODE_STD, 5'h00, 5'h00, 4'h8));
    rx(1'b0, 5'h01, 1'b0, ID1, 4'h8, D1);
    exp_tx(1'b1, 5'h05, 1'b0, D1);
    chk(txId, ID1);
    chk(txDlc, 4'h8);
    rd(5'h05, can_gw_pkg::REG_FGCR, 32'h0000_1f00, 32'h0000_0500);
    rd(5'h05, can_gw_pkg::REG_DATA_HI, 32'hffff_ffff, D1[63:32]);
    rx(1'b1, 5'h05, 1'b1, ID1, 4'h0, D2);
    exp_tx(1'b1, 5'h05, 1'b0, D1);
    $display("standard destination test done");
  endtask

  task automatic t_nocopy();
    wb(1'b1, 5'h01, can_gw_pkg::REG_FGCR, fg(can_gw_pkg::MODE_GW, 5'h05, 5'h00, 4'h0));
    wb(1'b1, 5'h05, can_gw_pkg::REG_ID, 32'h0000_0777);
    rx(1'b0, 5'h01, 1'b0, ID1, 4'h2, D2);
    no_tx();
    rd(5'h05, can_gw_pkg::REG_ID, 32'h1fff_ffff, 32'h0000_0777);
    rd(5'h05, can_gw_pkg::REG_DLC, 32'h0000_000f, 32'h0000_0008);
    rd(5'h05, can_gw_pkg::REG_DATA_LO, 32'hffff_ffff, D2[31:0]);
    rx(1'b1, 5'h01, 1'b0, ID1, 4'h2, D3);
    rd(5'h05, can_gw_pkg::REG_DATA_LO, 32'hffff_ffff, D2[31:0]);
    wb(1'b1, 5'h05, can_gw_pkg::REG_CTRL, 32'h0000_0025);
    wb(1'b1, 5'h01, can_gw_pkg::REG_FGCR, fg(can_gw_pkg::MODE_GW, 5'h05, 5'h00, 4'h4));
    rx(1'b0, 5'h01, 1'b0, ID1, 4'h2, D3);
    no_tx();
    rd(5'h05, can_gw_pkg::REG_CTRL, 32'h0000_0003, 32'h0000_0002);
    wb(1'b1, 5'h05, can_gw_pkg::REG_CTRL, 32'h0000_0016);
    exp_tx(1'b1, 5'h05, 1'b0, D3);
    $display("copy selection and update hold test done");
  endtask

  task automatic t_remote();
    wb(1'b1, 5'h05, can_gw_pkg::REG_FGCR, fg(can_gw_pkg::MODE_GW, 5'h01, 5'h00, 4'h8));
    slow <= 1'b1;
    rx(1'b1, 5'h05, 1'b1, ID1, 4'h0, D1);
    exp_tx(1'b0, 5'h01, 1'b1, D1);
    wb(1'b1, 5'h05, can_gw_pkg::REG_FGCR, fg(can_gw_pkg::MODE_GW, 5'h01, 5'h00, 4'h0));
    rx(1'b1, 5'h05, 1'b1, ID1, 4'h0, D1);
    exp_tx(1'b1, 5'h05, 1'b0, D3);
    // earlier remote send on node 0 must finish first, its done pulse clears the request
    wait (nodeBusy == 2'b00);
    wb(1'b1, 5'h01, can_gw_pkg::REG_CTRL, 32'h0000_0016);
    exp_tx(1'b0, 5'h01, 1'b1, D1);
    $display("remote forwarding test done");
  endtask

  task automatic t_fifo();
    for (int i = 8; i < 12; i++) begin
      cfg(i[4:0], 1'b1, 1'b1, fg(i == 8 ? 3'h2 : 3'h3, 5'h08, 5'h03, 4'h0));
    end
    wb(1'b1, 5'h01, can_gw_pkg::REG_FGCR, fg(can_gw_pkg::MODE_GW, 5'h0b, 5'h03, 4'h4));
    rx(1'b0, 5'h01, 1'b0, ID1, 4'h8, D1);
    exp_tx(1'b1, 5'h0b, 1'b0, D1);
    rd(5'h01, can_gw_pkg::REG_FGCR, 32'h0000_1f00, 32'h0000_0800);
    rx(1'b0, 5'h01, 1'b0, ID1, 4'h8, D2);
    exp_tx(1'b1, 5'h08, 1'b0, D2);
    rd(5'h01, can_gw_pkg::REG_FGCR, 32'h0000_1f00, 32'h0000_0900);
    wb(1'b1, 5'h01, can_gw_pkg::REG_FGCR, fg(can_gw_pkg::MODE_GW, 5'h09, 5'h03, 4'h0));
    rx(1'b0, 5'h01, 1'b0, ID1, 4'h8, D3);
    no_tx();
    rd(5'h01, can_gw_pkg::REG_FGCR, 32'h0000_1f00, 32'h0000_0a00);
    $display("fifo destination test done");
  endtask

  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_std();
    t_nocopy();
    t_remote();
    t_fifo();
    report_and_stop();
  end
endmodule
